// ---- design/term_reg_pkg.sv ----
// Package with constants and carrier types of the terminal register access logic.
package term_reg_pkg;

  // Control byte field positions.
  localparam int unsigned REG_MODE_BIT = 7;
  localparam int unsigned WRITE_BIT    = 6;
  localparam int unsigned NUM_MSB      = 5;
  localparam int unsigned NUM_WIDTH    = 6;

  // Register space.
  localparam int unsigned REG_COUNT  = 64;
  localparam int unsigned DATA_WIDTH = 16;

  // Register numbers.
  localparam logic [5:0] WRITE_UNLOCK_CODE_NUM = 6'h1f;
  localparam logic [5:0] FEATURE_SETTINGS_NUM  = 6'h20;

  // Value that lifts the write protection.
  localparam logic [15:0] UNLOCK_VALUE = 16'h1235;

  // Reset values and the write acknowledge mask.
  localparam logic [15:0] REG_RESET     = 16'h0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [7:0]  WRITE_ACK_MSK = 8'hbf;

  // Bytes that arrive from the controller through the process image.
  typedef struct packed {
    logic [7:0] control_byte;
    logic [7:0] data_high;
    logic [7:0] data_low;
  } image_out_type;

  // Bytes that go back to the controller through the process image.
  typedef struct packed {
    logic [7:0] status_byte;
    logic [7:0] data_high;
    logic [7:0] data_low;
  } image_in_type;

  // Decoded control byte.
  typedef struct packed {
    logic       reg_mode;
    logic       write;
    logic [5:0] register_number_field;
    logic       to_code_word;
    logic       to_user_reg;
  } request_type;

endpackage : term_reg_pkg

// ---- design/term_ctrl_decode.sv ----
// Decoder of the control byte of a register access.
`timescale 1ns/10ps

module term_ctrl_decode (
  // Control byte from the process image.
  input  wire logic [7:0]                 control_byte,
  // Decoded request.
  output term_reg_pkg::request_type       request
);

  function automatic logic [5:0] field_of(input logic [7:0] ctrl);
    field_of = ctrl[term_reg_pkg::NUM_MSB:0];
  endfunction : field_of

  always_comb begin
    request.reg_mode              = control_byte[term_reg_pkg::REG_MODE_BIT];
    request.write                 = control_byte[term_reg_pkg::WRITE_BIT];
    request.register_number_field = field_of(control_byte);
    request.to_code_word          = field_of(control_byte) ==
                                    term_reg_pkg::WRITE_UNLOCK_CODE_NUM;
    request.to_user_reg           = field_of(control_byte) >
                                    term_reg_pkg::WRITE_UNLOCK_CODE_NUM;
  end

endmodule : term_ctrl_decode

// ---- design/term_reg_access.sv ----
// Register access logic of a fieldbus terminal behind its process image.
`timescale 1ns/10ps

module term_reg_access #(
  parameter int unsigned REG_COUNT = term_reg_pkg::REG_COUNT
) (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Process image from the controller.
  input  wire logic                          image_valid,
  input  wire term_reg_pkg::image_out_type   image_out,
  // Process data produced by the measuring side.
  input  wire logic [7:0]                    process_status,
  input  wire logic [15:0]                   process_data,
  // Power-off/power-on restart event.
  input  wire logic                          restart,
  // Process image back to the controller.
  output term_reg_pkg::image_in_type         image_in,
  output logic                               answer_valid,
  // Process data bytes of the controller when not in register mode.
  output logic [15:0]                        process_out_data,
  output logic                               process_out_valid,
  // Terminal state.
  output logic                               write_enabled,
  output logic [15:0]                        feature_active
);

  typedef struct packed {
    logic [term_reg_pkg::REG_COUNT-1:0][15:0] regs;
    logic                                     unlocked;
    logic [15:0]                              feature_active;
    term_reg_pkg::image_in_type               answer;
    logic                                     answer_valid;
    logic [15:0]                              process_out;
    logic                                     process_out_valid;
  } state_type;

  state_type                 state_ff;
  state_type                 nxt_state;
  term_reg_pkg::request_type request;
  logic [15:0]               word_out;
  logic [REG_COUNT-1:0]      store_hit;

  // The state struct and the six-bit number field are sized for exactly this count.
  generate
    if (REG_COUNT != term_reg_pkg::REG_COUNT) begin : g_bad_count
      $error("REG_COUNT must equal the 64 registers that the six-bit number reaches.");
    end
  endgenerate

  // A write changes the stored word only where the protection lets it.
  function automatic logic store_allowed(
    input term_reg_pkg::request_type req,
    input logic                      unlocked
  );
    store_allowed = 1'b0;
    if (req.reg_mode && req.write) begin
      if (req.to_code_word) begin
        store_allowed = 1'b1;
      end else if (req.to_user_reg && unlocked) begin
        store_allowed = 1'b1;
      end
    end
  endfunction : store_allowed

  function automatic logic [7:0] receipt_of(
    input logic [7:0] ctrl,
    input logic       is_write
  );
    if (is_write) begin
      receipt_of = ctrl & term_reg_pkg::WRITE_ACK_MSK;
    end else begin
      receipt_of = ctrl;
    end
  endfunction : receipt_of

  // Only the exact code word opens the registers; anything else closes them again.
  function automatic logic unlock_after(
    input logic [15:0] word
  );
    if (word == term_reg_pkg::UNLOCK_VALUE) begin
      unlock_after = 1'b1;
    end else begin
      unlock_after = 1'b0;
    end
  endfunction : unlock_after

  // Answer of a register mode request; a write answer carries no data.
  function automatic term_reg_pkg::image_in_type reg_answer_of(
    input logic [7:0]  ctrl,
    input logic        is_write,
    input logic [15:0] stored
  );
    term_reg_pkg::image_in_type reply;
    reply.status_byte = receipt_of(ctrl, is_write);
    if (is_write) begin
      reply.data_high = term_reg_pkg::BYTE_RESET;
      reply.data_low  = term_reg_pkg::BYTE_RESET;
    end else begin
      reply.data_high = stored[15:8];
      reply.data_low  = stored[7:0];
    end
    return reply;
  endfunction : reg_answer_of

  // Answer of a process data request, built from the measuring side.
  function automatic term_reg_pkg::image_in_type process_answer_of(
    input logic [7:0]  status,
    input logic [15:0] data
  );
    term_reg_pkg::image_in_type reply;
    reply.status_byte = status;
    reply.data_high   = data[15:8];
    reply.data_low    = data[7:0];
    return reply;
  endfunction : process_answer_of

  term_ctrl_decode u_decode (
    .control_byte (image_out.control_byte),
    .request      (request)
  );

  // The word to store is high byte then low byte.
  assign word_out = {image_out.data_high, image_out.data_low};

  // One match line per register; at most one is high for a taken write.
  genvar reg_idx;
  generate
    for (reg_idx = 0; reg_idx < REG_COUNT; reg_idx++) begin : g_store_hit
      assign store_hit[reg_idx] = image_valid &&
        store_allowed(request, state_ff.unlocked) &&
        (request.register_number_field == 6'(reg_idx));
    end
  endgenerate

  always_comb begin
    nxt_state                   = state_ff;
    nxt_state.answer_valid      = 1'b0;
    nxt_state.process_out_valid = 1'b0;
    if (restart) begin
      // Stored settings take effect only here.
      nxt_state.feature_active = state_ff.regs[term_reg_pkg::FEATURE_SETTINGS_NUM];
    end
    for (int idx = 0; idx < REG_COUNT; idx++) begin
      if (store_hit[idx]) begin
        nxt_state.regs[idx] = word_out;
      end
    end
    if (image_valid) begin
      nxt_state.answer_valid = 1'b1;
      if (request.reg_mode) begin
        if (request.write && request.to_code_word) begin
          nxt_state.unlocked = unlock_after(word_out);
        end
        // A refused write is acknowledged all the same; a read ignores the data word.
        nxt_state.answer = reg_answer_of(image_out.control_byte, request.write,
          state_ff.regs[request.register_number_field]);
      end else begin
        nxt_state.answer            = process_answer_of(process_status, process_data);
        nxt_state.process_out       = word_out;
        nxt_state.process_out_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff.regs              <= '0;
      state_ff.unlocked          <= 1'b0;
      state_ff.feature_active    <= term_reg_pkg::REG_RESET;
      state_ff.answer            <= '0;
      state_ff.answer_valid      <= 1'b0;
      state_ff.process_out       <= term_reg_pkg::REG_RESET;
      state_ff.process_out_valid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign image_in          = state_ff.answer;
  assign answer_valid      = state_ff.answer_valid;
  assign process_out_data  = state_ff.process_out;
  assign process_out_valid = state_ff.process_out_valid;
  assign write_enabled     = state_ff.unlocked;
  assign feature_active    = state_ff.feature_active;

endmodule : term_reg_access

// ---- tb/term_reg_access_assertions.sv ----
// Checker of the terminal register access ports.
`timescale 1ns/10ps
module term_reg_access_assertions (
  // Clock, reset and requests.
  input wire logic clk, rst, image_valid, restart,
  input wire term_reg_pkg::image_out_type image_out,
  // Answers and state.
  input wire term_reg_pkg::image_in_type image_in,
  input wire logic answer_valid, process_out_valid, write_enabled,
  input wire logic [15:0] process_out_data, feature_active
);
  wire logic [7:0] c = image_out.control_byte;
  wire logic [15:0] w = {image_out.data_high, image_out.data_low};
  wire logic code_wr = image_valid && c == 8'hdf;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_write_ack_echo: assert property (image_valid && c[7] && c[6] |=> answer_valid
    && image_in.status_byte == ($past(c) & 8'hbf)) else $error("bad write ack");
  a_read_echo: assert property (image_valid && c[7] && !c[6] |=> answer_valid
    && image_in.status_byte == $past(c)) else $error("bad read echo");
  a_code_unlock: assert property (code_wr && w == term_reg_pkg::UNLOCK_VALUE
    |=> write_enabled) else $error("no unlock");
  a_code_relock: assert property (code_wr && w != term_reg_pkg::UNLOCK_VALUE
    |=> !write_enabled)
    else $error("no relock");
  a_lock_stable: assert property (!code_wr |=> $stable(write_enabled))
    else $error("lock moved");
  a_feature_wait: assert property (!restart |=> $stable(feature_active))
    else $error("feature moved");
  a_process_word: assert property (image_valid && !c[7] |=> process_out_valid
    && process_out_data == $past(w)) else $error("bad process word");
  a_reg_no_proc: assert property (image_valid && c[7] |=> !process_out_valid)
    else $error("process pulse in register mode");
  cover property (code_wr);
  cover property (restart);
  cover property (image_valid && !c[7]);
endmodule : term_reg_access_assertions

// ---- tb/controller_model.sv ----
// Controller model that places requests into the process image.
`timescale 1ns/10ps
module controller_model (
  // Clock.
  input wire logic clk,
  // Requests to the terminal.
  output logic image_valid,
  output term_reg_pkg::image_out_type image_out
);
  initial begin
    image_valid = 1'b0;
    image_out = 24'h00_0000;
  end
  // A released image shows the inverse, so stale bytes are never mistaken for a request.
  task automatic send(input logic [7:0] ctrl, input logic [15:0] word);
    @(posedge clk);
    image_valid <= 1'b1;
    image_out <= {ctrl, word[15:8], word[7:0]};
    @(posedge clk);
    image_valid <= 1'b0;
    image_out <= ~{ctrl, word};
  endtask : send
endmodule : controller_model

// ---- tb/test_terminal_register_access_protocol.sv ----
// Self-checking bench of the terminal register access logic.
`timescale 1ns/10ps
module test_terminal_register_access_protocol;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic restart = 1'b0;
  logic image_valid, answer_valid, process_out_valid, write_enabled;
  term_reg_pkg::image_out_type image_out;
  term_reg_pkg::image_in_type image_in;
  logic [15:0] process_out_data, feature_active;
  int n_errors = 0;
  int checked = 0;
  always #4 clk = ~clk;
  controller_model ctl (.clk(clk), .image_valid(image_valid), .image_out(image_out));
  term_reg_access uut (.clk(clk), .rst(rst), .image_valid(image_valid), .image_out(image_out),
    .process_status(8'h5a), .process_data(16'hc3a1), .restart(restart), .image_in(image_in),
    .answer_valid(answer_valid), .process_out_data(process_out_data),
    .process_out_valid(process_out_valid), .write_enabled(write_enabled),
    .feature_active(feature_active));
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic [7:0] ctrl, input logic [15:0] word);
    ctl.send(ctrl, word);
    #1;
  endtask : xfer
  task automatic locked_writes;
    xfer(8'he0, 16'h0002);
    check({answer_valid, image_in}, {1'b1, 24'ha0_0000});
    xfer(8'ha0, 16'hffff);
    check({answer_valid, image_in}, {1'b1, 24'ha0_0000});
    xfer(8'hc5, 16'h7777);
    xfer(8'h85, 16'h0000);
    check({answer_valid, image_in}, {1'b1, 24'h85_0000});
    xfer(8'hbf, 16'h0000);
    check({answer_valid, image_in}, {1'b1, 24'hbf_0000});
  endtask : locked_writes
  task automatic unlock_and_set;
    xfer(8'hdf, 16'h1235);
    check({write_enabled, image_in}, {1'b1, 24'h9f_0000});
    xfer(8'h9f, 16'habcd);
    check({answer_valid, image_in}, {1'b1, 24'h9f_1235});
    xfer(8'he0, 16'h0002);
    xfer(8'ha0, 16'h5555);
    check({answer_valid, image_in}, {1'b1, 24'ha0_0002});
    check({9'h000, feature_active}, {9'h000, 16'h0000});
    @(posedge clk) restart <= 1'b1;
    @(posedge clk) restart <= 1'b0;
    #1;
    check({9'h000, feature_active}, {9'h000, 16'h0002});
    xfer(8'hdf, 16'h0000);
    check({write_enabled, image_in}, {1'b0, 24'h9f_0000});
    xfer(8'he0, 16'h00ff);
    xfer(8'ha0, 16'h0000);
    check({answer_valid, image_in}, {1'b1, 24'ha0_0002});
  endtask : unlock_and_set
  task automatic cold_reset;
    xfer(8'hdf, 16'h1235);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({8'h00, write_enabled, feature_active}, {9'h000, 16'h0000});
    xfer(8'ha0, 16'h0000);
    check({answer_valid, image_in}, {1'b1, 24'ha0_0000});
  endtask : cold_reset
  task automatic process_path;
    xfer(8'h45, 16'h1234);
    check({answer_valid, image_in}, {1'b1, 24'h5a_c3a1});
    check({8'h00, process_out_valid, process_out_data}, {9'h001, 16'h1234});
  endtask : process_path
  task automatic print_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    locked_writes();
    unlock_and_set();
    process_path();
    cold_reset();
    print_verdict();
  end
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
endmodule : test_terminal_register_access_protocol
bind term_reg_access term_reg_access_assertions chk (.*);
